/* rtcs_event_flags.sv */
// Bank of sticky event flags that software clears by writing zero.
// Assumes set and clear are one-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none
module rtcs_event_flags #(
    parameter int N = 5
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Hardware events and software clears.
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    // Flag state.
    output logic      [N-1:0] flag
);

    logic [N-1:0] next_flag;

    // A set in the same cycle as a clear wins, so no event is lost.
    generate
        for (genvar i = 0; i < N; i++) begin : g_flag
            always_comb begin
                next_flag[i] = set[i] | (flag[i] & ~clr[i]);
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule : rtcs_event_flags
`default_nettype wire

/* rtcs_pkg.sv */
// Package for the real-time clock status and flag logic.
// Assumes a word-wide register port and one system clock.
package rtcs_pkg;

    // Register map.
    localparam logic [7:0]  STAT_OFFSET    = 8'h0c;
    localparam logic [31:0] STAT_RESET     = 32'h0000_0007;

    // Bit positions of the status register.
    localparam int          POS_CAL_PEND   = 16;
    localparam int          POS_TAMPER1    = 14;
    localparam int          POS_TAMPER0    = 13;
    localparam int          POS_STAMP_OVR  = 12;
    localparam int          POS_STAMP      = 11;
    localparam int          POS_ALARM0     = 8;
    localparam int          POS_INIT_REQ   = 7;
    localparam int          POS_INIT_STATE = 6;
    localparam int          POS_SYNCED     = 5;
    localparam int          POS_YEAR_MARK  = 4;
    localparam int          POS_SHIFT      = 3;
    localparam int          POS_ALARM_WR   = 0;

    // Bits that stay writable while write protection is active.
    localparam logic [31:0] UNPROT_MASK    = 32'h0000_7f00;

    // Shadow copy period, counted in rtc clock ticks.
    localparam int          SYNC_TICKS     = 2;

    // Number of clear-by-zero event flags kept in the flag bank.
    localparam int          NUM_EVENTS     = 5;

endpackage : rtcs_pkg

/* rtcs_shadow_sync.sv */
// Divider that issues a shadow copy pulse every few rtc clock ticks.
// Assumes tick is a one-cycle pulse per rtc clock period.
`timescale 1ns/1ps
`default_nettype none
module rtcs_shadow_sync
    import rtcs_pkg::*;
#(
    parameter int TICKS = SYNC_TICKS
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Tick and hold-off.
    input  wire logic tick,
    input  wire logic block,
    // Copy pulse.
    output logic      load
);

    localparam int CW = $clog2(TICKS + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_load;

    // While blocked the divider restarts, so the first copy after a
    // hold-off comes a full period later.
    always_comb begin
        next_cnt  = cnt;
        next_load = 1'b0;
        if (block) begin
            next_cnt = '0;
        end else if (tick) begin
            if (cnt == CW'(TICKS - 1)) begin
                next_cnt  = '0;
                next_load = 1'b1;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= '0;
            load <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            load <= next_load;
        end
    end

endmodule : rtcs_shadow_sync
`default_nettype wire

/* rtcs_status.sv */
// Status and flag register of the real-time clock unit.
// Assumes event inputs are one-cycle pulses and levels are synchronous
// to CLK; the protection level comes from the unlock logic elsewhere.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - System reset clears init request, state, synced.
// - Backup reset loads status value 0x7.
// - Protection blocks writes except bits 14:8.
// - Calibration write sets pending; window end clears.
// - Tamper events set their detected flags.
// - Writing zero clears an event flag.
// - Stamp while stamp flag set sets overflow.
// - Stamp event sets the stamp flag.
// - Alarm-0 match sets the alarm flag.
// - Init request stops counter; zero resumes.
// - Init state follows entry; gates calendar writes.
// - Shadow copy every two rtc ticks sets synced.
// - Init, shift, bypass or zero write clear synced.
// - Nonzero year sets the year mark.
// - Shift pending flag mirrors pending shift.
// - Alarm writable after enable clears; gates programming.
// - Bypass makes calendar reads return live values.
module rtcs_status
    import rtcs_pkg::*;
#(
    parameter int AW = 8
) (
    // Clock and resets.
    input  wire logic          CLK,
    input  wire logic          RSTN,
    input  wire logic          SYS_RSTN,
    // Register port.
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [31:0]   WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [31:0]   RDATA,
    input  wire logic          WRITE_PROT,
    // Events from the rest of the unit.
    input  wire logic          RTC_TICK,
    input  wire logic          CAL_WRITE,
    input  wire logic          CAL_DONE,
    input  wire logic          TAMPER1_EVENT,
    input  wire logic          TAMPER0_EVENT,
    input  wire logic          STAMP_EVENT,
    input  wire logic          ALARM0_MATCH,
    // Levels from the rest of the unit.
    input  wire logic          SHADOW_BYPASS,
    input  wire logic          SHIFT_PENDING,
    input  wire logic          ALARM0_ENABLE,
    input  wire logic [7:0]    YEAR,
    // Controls to the rest of the unit.
    output logic               COUNTER_STOP,
    output logic               CALENDAR_WRITE_EN,
    output logic               ALARM_WRITE_EN,
    output logic               SHADOW_LOAD,
    output logic               CAL_READ_LIVE
);

    ////////////////////////////////////////////////////////////////////
    // Register access decode.

    function automatic logic hits_stat(input logic [AW-1:0] a);
        hits_stat = (a == AW'(STAT_OFFSET));
    endfunction : hits_stat

    logic        wr_stat;
    logic [31:0] wr_mask;
    logic [31:0] wr_val;
    logic        init_rst_n;

    // Both resets clear the init and sync bits; others see backup only.
    assign init_rst_n = RSTN & SYS_RSTN;
    assign wr_stat    = WR && hits_stat(ADDR);
    assign wr_mask    = WRITE_PROT ? UNPROT_MASK : 32'hffff_ffff;
    assign wr_val     = WDATA | ~wr_mask;

    ////////////////////////////////////////////////////////////////////
    // Event flags: tamper1, tamper0, stamp overflow, stamp, alarm0.

    logic [NUM_EVENTS-1:0] ev_set;
    logic [NUM_EVENTS-1:0] ev_clr;
    logic [NUM_EVENTS-1:0] ev_flag;
    logic                  stamp_flag;

    assign stamp_flag = ev_flag[1];

    always_comb begin
        ev_set = {TAMPER1_EVENT, TAMPER0_EVENT,
                  STAMP_EVENT & stamp_flag,
                  STAMP_EVENT,
                  ALARM0_MATCH};
        ev_clr = '0;
        if (wr_stat) begin
            // Only a zero clears; a one keeps the flag.
            ev_clr = ~{wr_val[POS_TAMPER1], wr_val[POS_TAMPER0],
                       wr_val[POS_STAMP_OVR], wr_val[POS_STAMP],
                       wr_val[POS_ALARM0]};
        end
    end

    rtcs_event_flags #(
        .N     (NUM_EVENTS)
    ) u_flags (
        .clk   (CLK),
        .rst_n (RSTN),
        .set   (ev_set),
        .clr   (ev_clr),
        .flag  (ev_flag)
    );

    ////////////////////////////////////////////////////////////////////
    // Shadow copy divider.

    logic sync_block;

    assign sync_block = COUNTER_STOP | SHIFT_PENDING | SHADOW_BYPASS;

    rtcs_shadow_sync #(
        .TICKS (SYNC_TICKS)
    ) u_sync (
        .clk   (CLK),
        .rst_n (RSTN),
        .tick  (RTC_TICK),
        .block (sync_block),
        .load  (SHADOW_LOAD)
    );

    ////////////////////////////////////////////////////////////////////
    // Init request, init state and sync flag.

    logic next_init_req;
    logic next_init_state;
    logic synced;
    logic next_synced;

    always_comb begin
        next_init_req   = COUNTER_STOP;
        if (wr_stat && wr_mask[POS_INIT_REQ]) begin
            next_init_req = WDATA[POS_INIT_REQ];
        end
        // Entry is acknowledged one cycle after the counter stops.
        next_init_state = COUNTER_STOP & next_init_req;
        next_synced     = synced;
        if (COUNTER_STOP || SHIFT_PENDING || SHADOW_BYPASS) begin
            next_synced = 1'b0;
        end else if (SHADOW_LOAD) begin
            next_synced = 1'b1;
        end else if (wr_stat && !wr_val[POS_SYNCED]) begin
            next_synced = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge init_rst_n) begin
        if (!init_rst_n) begin
            COUNTER_STOP      <= STAT_RESET[POS_INIT_REQ];
            CALENDAR_WRITE_EN <= STAT_RESET[POS_INIT_STATE];
            synced            <= STAT_RESET[POS_SYNCED];
        end else begin
            COUNTER_STOP      <= next_init_req;
            CALENDAR_WRITE_EN <= next_init_state;
            synced            <= next_synced;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration pending and mirrored state.

    logic cal_pend;
    logic next_cal_pend;
    logic year_mark;
    logic next_year_mark;
    logic shift_flag;
    logic next_shift_flag;
    logic next_alarm_wr;
    logic next_live;

    always_comb begin
        next_cal_pend = cal_pend;
        if (CAL_WRITE) begin
            next_cal_pend = 1'b1;
        end else if (CAL_DONE) begin
            next_cal_pend = 1'b0;
        end
        next_year_mark  = (YEAR != 8'h00);
        next_shift_flag = SHIFT_PENDING;
        next_alarm_wr   = ~ALARM0_ENABLE;
        next_live       = SHADOW_BYPASS;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cal_pend       <= STAT_RESET[POS_CAL_PEND];
            year_mark      <= STAT_RESET[POS_YEAR_MARK];
            shift_flag     <= STAT_RESET[POS_SHIFT];
            ALARM_WRITE_EN <= STAT_RESET[POS_ALARM_WR];
            CAL_READ_LIVE  <= 1'b0;
        end else begin
            cal_pend       <= next_cal_pend;
            year_mark      <= next_year_mark;
            shift_flag     <= next_shift_flag;
            ALARM_WRITE_EN <= next_alarm_wr;
            CAL_READ_LIVE  <= next_live;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe.

    logic [31:0] status;
    logic [31:0] next_rdata;

    always_comb begin
        status                 = '0;
        status[2:1]            = STAT_RESET[2:1];
        status[POS_CAL_PEND]   = cal_pend;
        status[POS_TAMPER1]    = ev_flag[4];
        status[POS_TAMPER0]    = ev_flag[3];
        status[POS_STAMP_OVR]  = ev_flag[2];
        status[POS_STAMP]      = ev_flag[1];
        status[POS_ALARM0]     = ev_flag[0];
        status[POS_INIT_REQ]   = COUNTER_STOP;
        status[POS_INIT_STATE] = CALENDAR_WRITE_EN;
        status[POS_SYNCED]     = synced;
        status[POS_YEAR_MARK]  = year_mark;
        status[POS_SHIFT]      = shift_flag;
        status[POS_ALARM_WR]   = ALARM_WRITE_EN;
        next_rdata             = '0;
        if (RD && hits_stat(ADDR)) begin
            next_rdata = status;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= '0;
        end else begin
            RDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN || !SYS_RSTN);

    sequence s_stamp_clear;
        wr_stat && !WRITE_PROT && !WDATA[POS_STAMP] && !STAMP_EVENT;
    endsequence

    sequence s_sync_blocked;
        COUNTER_STOP || SHIFT_PENDING || SHADOW_BYPASS;
    endsequence

    sequence s_free_run;
        !COUNTER_STOP && !SHIFT_PENDING && !SHADOW_BYPASS;
    endsequence

    a_cal_pend_set: assert property (CAL_WRITE |=> status[POS_CAL_PEND])
        else $error("calibration pending not set");
    a_cal_pend_clr: assert property (
        CAL_DONE && !CAL_WRITE |=> !status[POS_CAL_PEND])
        else $error("calibration pending not cleared");
    a_tamper_set: assert property (
        TAMPER1_EVENT |=> status[POS_TAMPER1])
        else $error("tamper1 flag not set");
    a_stamp_clear: assert property (s_stamp_clear |=> !stamp_flag)
        else $error("stamp flag not cleared by zero");
    a_one_keeps: assert property (
        wr_stat && WDATA[POS_ALARM0] && !ALARM0_MATCH
        |=> ev_flag[0] == $past(ev_flag[0]))
        else $error("writing one changed alarm flag");
    a_stamp_ovr: assert property (
        STAMP_EVENT && stamp_flag |=> status[POS_STAMP_OVR])
        else $error("stamp overflow not set");
    a_stamp_set: assert property (STAMP_EVENT |=> stamp_flag)
        else $error("stamp flag not set");
    a_alarm_set: assert property (ALARM0_MATCH |=> ev_flag[0])
        else $error("alarm flag not set");
    a_init_enter: assert property (
        wr_stat && !WRITE_PROT && WDATA[POS_INIT_REQ]
        |=> COUNTER_STOP ##1 CALENDAR_WRITE_EN)
        else $error("init entry sequence wrong");
    a_protect_init: assert property (
        wr_stat && WRITE_PROT |=> $stable(COUNTER_STOP))
        else $error("protected write changed init request");
    a_sync_block: assert property (
        s_sync_blocked |=> !synced)
        else $error("synced flag not cleared");
    a_sync_set: assert property (
        s_free_run ##0 SHADOW_LOAD |=> synced)
        else $error("synced flag not set on copy");
    a_year_mark: assert property (
        ##1 year_mark == ($past(YEAR) != 8'h00))
        else $error("year mark wrong");
    a_shift_flag: assert property (
        SHIFT_PENDING [*2] |-> shift_flag)
        else $error("shift flag does not follow");
    a_alarm_wr: assert property (
        $fell(ALARM0_ENABLE) |=> ALARM_WRITE_EN)
        else $error("alarm writable flag not set");
    a_bypass_live: assert property (
        SHADOW_BYPASS |=> CAL_READ_LIVE)
        else $error("bypass not forwarded");

endmodule : rtcs_status
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the status and flag register.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("ERROR at %0t: got %h expected %h", $time, g, e); \
    end \
end
module tb_top;
    import rtcs_pkg::*;
    logic        clk, rstn, sys_rstn, wr_s, rd_s, wprot, rd_q;
    logic        bypass, shift, alm_en, cstop, cal_wen, alm_wen;
    logic        sload, live;
    logic [7:0]  addr, year;
    logic [6:0]  ev;
    logic [31:0] wdata, rdata, r, exp_v;
    logic [31:0] notes[$];
    int          bad_count, checks_done, loads, l0;

    rtcs_status dut_u (.CLK(clk), .RSTN(rstn), .SYS_RSTN(sys_rstn),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .WRITE_PROT(wprot), .RTC_TICK(ev[0]), .CAL_WRITE(ev[1]),
        .CAL_DONE(ev[2]), .TAMPER1_EVENT(ev[3]), .TAMPER0_EVENT(ev[4]),
        .STAMP_EVENT(ev[5]), .ALARM0_MATCH(ev[6]),
        .SHADOW_BYPASS(bypass), .SHIFT_PENDING(shift),
        .ALARM0_ENABLE(alm_en), .YEAR(year), .COUNTER_STOP(cstop),
        .CALENDAR_WRITE_EN(cal_wen), .ALARM_WRITE_EN(alm_wen),
        .SHADOW_LOAD(sload), .CAL_READ_LIVE(live));

    initial clk = 1'b0;
    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    // Result watcher: each read answer is matched with the oldest note.
    always @(posedge clk) begin
        rd_q <= rd_s;
        if (sload === 1'b1) loads <= loads + 1;
    end
    always @(negedge clk) begin
        if (rd_q === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                exp_v = notes.pop_front();
                `CHK(rdata, exp_v)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back(e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
    endtask : rd

    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h00;
        cyc(2);
    endtask : pulse

    task automatic tally_and_finish;
        if (notes.size() != 0) begin
            bad_count++;
        end
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // A hung run is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, wr_s, rd_s, wprot, bypass, shift, alm_en} = '0;
        {addr, year, ev, wdata} = '0;
        sys_rstn = 1'b1;
        void'($urandom(36402));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        cyc(2);
        rd(8'h0c, 32'h0000_0007);
        $display("test reset done");
        pulse(7'h78);
        pulse(7'h20);
        rd(8'h0c, 32'h0000_7907);
        wprot <= 1'b1;
        r = $urandom() & 32'h0000_7900;
        wr(8'h0c, r | 32'h0000_0107);
        rd(8'h0c, r | 32'h0000_0107);
        wr(8'h0c, 32'h0000_0007);
        rd(8'h0c, 32'h0000_0007);
        $display("test event flags done");
        pulse(7'h10);
        wr(8'h0c, 32'h0000_2087);
        cyc(0);
        `CHK(cstop, 1'b0)
        rd(8'h0c, 32'h0000_2007);
        wr(8'h08, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        rd(8'h0c, 32'h0000_2007);
        wr(8'h0c, 32'h0000_0007);
        wprot <= 1'b0;
        $display("test protection done");
        wr(8'h0c, 32'h0000_0087);
        cyc(0);
        `CHK(cstop, 1'b1)
        cyc(1);
        `CHK(cal_wen, 1'b1)
        pulse(7'h08);
        rd(8'h0c, 32'h0000_40c7);
        @(posedge clk);
        sys_rstn <= 1'b0;
        @(posedge clk);
        sys_rstn <= 1'b1;
        cyc(1);
        rd(8'h0c, 32'h0000_4007);
        `CHK(cstop, 1'b0)
        wr(8'h0c, 32'h0000_0087);
        wr(8'h0c, 32'h0000_0007);
        cyc(0);
        `CHK({cstop, cal_wen}, 2'b00)
        $display("test init done");
        l0 = loads;
        repeat (4) pulse(7'h01);
        cyc(2);
        `CHK(loads - l0, 2)
        rd(8'h0c, 32'h0000_0027);
        shift <= 1'b1;
        cyc(2);
        rd(8'h0c, 32'h0000_000f);
        shift <= 1'b0;
        repeat (2) pulse(7'h01);
        rd(8'h0c, 32'h0000_0027);
        wr(8'h0c, 32'h0000_0007);
        rd(8'h0c, 32'h0000_0007);
        bypass <= 1'b1;
        cyc(2);
        `CHK(live, 1'b1)
        repeat (2) pulse(7'h01);
        rd(8'h0c, 32'h0000_0007);
        bypass <= 1'b0;
        $display("test shadow sync done");
        year <= 8'(($urandom() % 255) + 1);
        cyc(2);
        rd(8'h0c, 32'h0000_0017);
        year <= 8'h00;
        pulse(7'h02);
        rd(8'h0c, 32'h0001_0007);
        pulse(7'h04);
        rd(8'h0c, 32'h0000_0007);
        alm_en <= 1'b1;
        cyc(2);
        `CHK(alm_wen, 1'b0)
        rd(8'h0c, 32'h0000_0006);
        alm_en <= 1'b0;
        cyc(2);
        rd(8'h0c, 32'h0000_0007);
        $display("test year calib alarm done");
        cyc(3);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
